// ### design/pmt_pkg.sv
// shared constants for the program memory table-read block
package pmt_pkg;
    localparam int          PMT_PC_W        = 14;
    localparam int          PMT_WORD_W      = 16;
    localparam int          PMT_PAGE_W      = 8;
    localparam int          PMT_EE_AW       = 8;
    localparam logic [13:0] PMT_RESET_VEC   = 14'h0000;
    localparam logic [7:0]  PMT_TABLE_HIGH_LATCH_RST    = 8'h00;
    localparam int          PMT_TABLE_CYC   = 2;
    localparam logic [7:0]  PMT_CMD_PROG_WR = 8'h01;
    localparam logic [7:0]  PMT_CMD_PROG_RD = 8'h02;
    localparam logic [7:0]  PMT_CMD_EE_WR   = 8'h03;
    localparam logic [7:0]  PMT_CMD_EE_RD   = 8'h04;
    localparam int          PMT_FRAME_BITS  = 40;

    typedef enum logic [1:0] {
        PMT_FETCH  = 2'b00,
        PMT_TABLE  = 2'b01,
        PMT_PROG   = 2'b11
    } pmt_state_e;
endpackage : pmt_pkg

// ### design/pmt_serial_link.sv
// serial programming shifter on the programmer's clock
`timescale 1ns/1ps
module pmt_serial_link
    import pmt_pkg::*;
(
    // link side
    input  wire logic        prog_clock_pin,
    input  wire logic        link_rst_b,
    input  wire logic        prog_data_in,
    output logic             prog_data_out,
    output logic             prog_data_oe,
    // frame toward core
    output logic [39:0]      frame_q,
    output logic             frame_tgl_q,
    // read data from core, stable while frame in flight
    input  wire logic [15:0] rd_word
);
    logic [5:0]  bit_cnt_q;
    logic [15:0] out_sr_q;
    logic        resp_q;
    logic        done_q;

    // shift in on rising edge; frame = cmd[8] addr[16] data[16]
    always_ff @(posedge prog_clock_pin or negedge link_rst_b) begin
        if (!link_rst_b) begin
            frame_q     <= '0;
            bit_cnt_q   <= '0;
            frame_tgl_q <= 1'b0;
            done_q      <= 1'b0;
        end else if (!resp_q) begin
            frame_q <= {frame_q[38:0], prog_data_in};
            if (bit_cnt_q == 6'(PMT_FRAME_BITS - 1)) begin
                bit_cnt_q   <= '0;
                frame_tgl_q <= ~frame_tgl_q;
                done_q      <= 1'b1;
            end else begin
                bit_cnt_q <= bit_cnt_q + 6'd1;
                done_q    <= 1'b0;
            end
        end else begin
            done_q    <= 1'b0;
            bit_cnt_q <= (bit_cnt_q == 6'd15) ? 6'd0 : bit_cnt_q + 6'd1;
        end
    end

    // read frames answer with 16 bits driven on falling edges
    always_ff @(negedge prog_clock_pin or negedge link_rst_b) begin
        if (!link_rst_b) begin
            resp_q   <= 1'b0;
            out_sr_q <= '0;
        end else if (!resp_q && done_q &&
                     (frame_q[39:32] == PMT_CMD_PROG_RD ||
                      frame_q[39:32] == PMT_CMD_EE_RD)) begin
            resp_q   <= 1'b1;
            out_sr_q <= rd_word;
        end else if (resp_q) begin
            // sixteenth rising edge has taken the last bit
            if (bit_cnt_q == 6'd0) begin
                resp_q <= 1'b0;
            end else begin
                out_sr_q <= {out_sr_q[14:0], 1'b0};
            end
        end
    end

    assign prog_data_out = out_sr_q[15];
    assign prog_data_oe  = resp_q;
endmodule : pmt_serial_link

// ### design/pmt_table_read.sv
// program memory fetch, table read and in-circuit programming access
//
// Behaviour
// - after any reset the program counter is 000H and fetching starts there.
// - table address is high pointer concatenated above low pointer.
// - table read writes program word low byte to operand data register.
// - same table read puts the word's upper part in the high latch.
// - unused upper latch bits read zero for narrow program words.
// - high latch is read-only; only table reads change it.
// - every table instruction takes two instruction cycles.
// - current-page variant uses low pointer as offset in current page.
// - programmer holds reset low; device halts and yields data/clock pins.
// - data moves both ways on one pin, clocked by programmer's clock.
// - flash program memory and EEPROM both writable and readable serially.
// - port A bit 0 is serial data, bit 2 serial clock, while programming.
`timescale 1ns/1ps
module pmt_table_read
    import pmt_pkg::*;
#(
    parameter int PC_W    = PMT_PC_W,
    parameter int WORD_W  = 15,
    parameter int EE_AW   = PMT_EE_AW
)(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    // core requests
    input  wire logic              table_rd_req,
    input  wire logic              table_read_alt_op,
    input  wire logic [7:0]        tbl_ptr_lo,
    input  wire logic [7:0]        tbl_ptr_hi,
    input  wire logic [7:0]        operand_addr,
    input  wire logic              pc_advance,
    // core results
    output logic [PC_W-1:0]        pc_q,
    output logic [WORD_W-1:0]      instr_q,
    output logic                   instr_valid_q,
    output logic                   table_busy_q,
    output logic                   dm_we_q,
    output logic [7:0]             dm_addr_q,
    output logic [7:0]             dm_wdata_q,
    output logic [7:0]             table_high_latch,
    output logic                   core_halt_q,
    // port a bits 0 and 2 normal use
    input  wire logic              pa0_out,
    input  wire logic              pa0_oe,
    output logic                   pa0_in_q,
    output logic                   pa2_in_q,
    // pins
    input  wire logic              chip_clear_pin_n,
    input  wire logic              prog_data_pin_i,
    output logic                   prog_data_pin_o,
    output logic                   prog_data_pin_oe,
    input  wire logic              prog_clock_pin
);
    localparam int HI_W = WORD_W - 8;

    logic [WORD_W-1:0] pmem [0:(1<<PC_W)-1];
    logic [7:0]        eemem [0:(1<<EE_AW)-1];

    pmt_state_e        state_q;
    logic [1:0]        clr_sync_q;
    logic [2:0]        tgl_sync_q;
    logic [1:0]        pa_sync_q [0:1];
    logic [PC_W-1:0]   tbl_addr_q;
    logic [7:0]        tbl_dst_q;
    logic [15:0]       rd_word_q;
    logic              prog_mode;

    logic [39:0]       frame;
    logic              frame_tgl;
    logic              link_data_o;
    logic              link_data_oe;
    logic              frame_evt;
    logic              table_cycle;
    logic [WORD_W-1:0] tbl_word;
    logic [HI_W-1:0]   tbl_hi;

    // command field of a received frame
    function automatic logic cmd_is(input logic [39:0] f,
                                    input logic [7:0]  c);
        return f[39:32] == c;
    endfunction : cmd_is

    // reset pin held low by programmer selects programming mode
    // idle level high after reset, so no false programming entry
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clr_sync_q <= 2'b11;
        end else begin
            clr_sync_q <= {clr_sync_q[0], chip_clear_pin_n};
        end
    end
    assign prog_mode = ~clr_sync_q[1];

    // function of a pin is port bit unless programming
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pa_sync
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) pa_sync_q[gi] <= 2'b00;
                else pa_sync_q[gi] <= {pa_sync_q[gi][0],
                    (gi == 0) ? prog_data_pin_i : prog_clock_pin};
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pa0_in_q <= 1'b0;
            pa2_in_q <= 1'b0;
            prog_data_pin_o  <= 1'b0;
            prog_data_pin_oe <= 1'b0;
        end else begin
            pa0_in_q <= prog_mode ? 1'b0 : pa_sync_q[0][1];
            pa2_in_q <= prog_mode ? 1'b0 : pa_sync_q[1][1];
            prog_data_pin_o  <= prog_mode ? link_data_o  : pa0_out;
            prog_data_pin_oe <= prog_mode ? link_data_oe : pa0_oe;
        end
    end

    // programmer-clocked shifter; held in reset outside programming
    pmt_serial_link u_link (
        .prog_clock_pin (prog_clock_pin),
        .link_rst_b     (chip_clear_pin_n ? 1'b0 : rst_b),
        .prog_data_in   (prog_data_pin_i),
        .prog_data_out  (link_data_o),
        .prog_data_oe   (link_data_oe),
        .frame_q        (frame),
        .frame_tgl_q    (frame_tgl),
        .rd_word        (rd_word_q)
    );

    // frame toggle crossing; frame word stable until the first rising edge of the next frame
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) tgl_sync_q <= 3'b000;
        else        tgl_sync_q <= {tgl_sync_q[1:0], frame_tgl};
    end

    // one strobe per received frame, only while programming
    assign frame_evt = prog_mode && (tgl_sync_q[2] != tgl_sync_q[1]);

    // memory access from programmer
    always_ff @(posedge ref_clk) begin
        if (frame_evt) begin
            if (cmd_is(frame, PMT_CMD_PROG_WR))
                pmem[frame[PC_W+15:16]] <= frame[WORD_W-1:0];
            if (cmd_is(frame, PMT_CMD_EE_WR))
                eemem[frame[EE_AW+15:16]] <= frame[7:0];
        end
    end

    // read word is shifted out on the following read frame
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_word_q <= '0;
        end else if (frame_evt) begin
            if (cmd_is(frame, PMT_CMD_PROG_RD))
                rd_word_q <= 16'(pmem[frame[PC_W+15:16]]);
            else if (cmd_is(frame, PMT_CMD_EE_RD))
                rd_word_q <= {8'h00, eemem[frame[EE_AW+15:16]]};
        end
    end

    // core sequencing state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= PMT_FETCH;
        end else if (prog_mode) begin
            state_q <= PMT_PROG;
        end else begin
            case (state_q)
                PMT_FETCH: begin
                    if (table_rd_req) begin
                        state_q <= PMT_TABLE;
                    end
                end
                PMT_TABLE: begin
                    state_q <= PMT_FETCH;
                end
                default: begin
                    state_q <= PMT_FETCH;
                end
            endcase
        end
    end

    // program counter; back to the vector on every exit from reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_q <= PC_W'(PMT_RESET_VEC);
        end else if (prog_mode || state_q == PMT_PROG) begin
            pc_q <= PC_W'(PMT_RESET_VEC);
        end else if (state_q == PMT_TABLE) begin
            pc_q <= pc_q + PC_W'(1);
        end else if (!table_rd_req && pc_advance) begin
            pc_q <= pc_q + PC_W'(1);
        end
    end

    // table pointer and destination captured with the request
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tbl_addr_q <= '0;
            tbl_dst_q  <= '0;
        end else if (!prog_mode && state_q == PMT_FETCH && table_rd_req) begin
            tbl_dst_q <= operand_addr;
            if (table_read_alt_op)
                tbl_addr_q <= PC_W'({tbl_ptr_hi, tbl_ptr_lo});
            else
                tbl_addr_q <= {pc_q[PC_W-1:8], tbl_ptr_lo};
        end
    end

    // busy for the extra cycle of a table instruction
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            table_busy_q <= 1'b0;
        end else begin
            table_busy_q <= !prog_mode && state_q == PMT_FETCH &&
                            table_rd_req;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_halt_q <= 1'b1;
        end else begin
            core_halt_q <= prog_mode;
        end
    end

    // program memory port: fetch, or table word in the stall cycle
    assign table_cycle = (state_q == PMT_TABLE) && !prog_mode;
    assign tbl_word    = pmem[tbl_addr_q];
    assign tbl_hi      = tbl_word[WORD_W-1:8];

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            instr_q       <= '0;
            instr_valid_q <= 1'b0;
        end else if (state_q == PMT_FETCH && !prog_mode) begin
            instr_q       <= pmem[pc_q];
            instr_valid_q <= 1'b1;
        end else begin
            instr_valid_q <= 1'b0;
        end
    end

    // low byte to the operand register, one-cycle strobe
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dm_we_q    <= 1'b0;
            dm_addr_q  <= '0;
            dm_wdata_q <= '0;
        end else begin
            dm_we_q <= table_cycle;
            if (table_cycle) begin
                dm_addr_q  <= tbl_dst_q;
                dm_wdata_q <= tbl_word[7:0];
            end
        end
    end

    // no write path reaches the latch; zero fill above the word
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            table_high_latch <= PMT_TABLE_HIGH_LATCH_RST;
        end else if (table_cycle) begin
            table_high_latch <= 8'(tbl_hi);
        end
    end
endmodule : pmt_table_read

// ### tb/pmt_table_read_sva.sv
// assertion checker for the table-read block
`timescale 1ns/1ps
module pmt_table_read_sva
    import pmt_pkg::*;
#(
    parameter int PC_W   = PMT_PC_W,
    parameter int WORD_W = 15
)(
    // clock and reset
    input wire logic            ref_clk,
    input wire logic            rst_b,
    // watched ports
    input wire logic [7:0]      operand_addr,
    input wire logic [PC_W-1:0] pc_q,
    input wire logic            instr_valid_q,
    input wire logic            table_busy_q,
    input wire logic            dm_we_q,
    input wire logic [7:0]      dm_addr_q,
    input wire logic [7:0]      table_high_latch,
    input wire logic            core_halt_q,
    input wire logic            pa0_in_q,
    input wire logic            pa2_in_q,
    input wire logic            chip_clear_pin_n,
    input wire logic            prog_data_pin_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    busy_to_we_a: assert property (table_busy_q |=> dm_we_q && !table_busy_q)
        else $error("table read did not finish in two cycles");
    we_pulse_a: assert property (dm_we_q |=> !dm_we_q)
        else $error("data write strobe longer than one cycle");
    we_dest_a: assert property (dm_we_q |-> dm_addr_q == $past(operand_addr, 2))
        else $error("low byte sent to wrong register");
    latch_ro_a: assert property (!$stable(table_high_latch) |-> dm_we_q)
        else $error("high latch changed outside a table read");
    latch_pad_a: assert property ((table_high_latch >> (WORD_W - 8)) == 8'h00)
        else $error("unused high latch bits not zero");
    stall_a: assert property (table_busy_q |=> !instr_valid_q)
        else $error("fetch not stalled in table cycle");
    halt_prog_a: assert property (!chip_clear_pin_n [*4] |-> core_halt_q && !table_busy_q)
        else $error("core not halted while programming");
    pins_prog_a: assert property (!chip_clear_pin_n [*4] |-> !pa0_in_q && !pa2_in_q)
        else $error("port pins not taken from core");
    pc_vec_a: assert property ($fell(core_halt_q) |-> pc_q == '0)
        else $error("program counter not at reset vector");

    cover property (table_busy_q ##1 dm_we_q);
    cover property (prog_data_pin_oe);
    cover property ($fell(core_halt_q));
endmodule : pmt_table_read_sva

bind pmt_table_read pmt_table_read_sva #(.PC_W(PC_W), .WORD_W(WORD_W))
    pmt_table_read_sva_i (.*);

// ### tb/pmt_programmer.sv
// programmer model: sends frames and reads answers on the data pin
`timescale 1ns/1ps
module pmt_programmer
    import pmt_pkg::*;
(
    // link pins
    output logic      prog_clock_pin,
    output logic      drv_val,
    input  wire logic pin_level
);
    initial begin
        prog_clock_pin = 1'b0;
        drv_val        = 1'b0;
    end

    // clock stands low between frames
    task automatic frame(input logic [7:0] cmd, input logic [15:0] adr,
                         input logic [15:0] dat, output logic [15:0] rd);
        logic [39:0] bits;
        bits = {cmd, adr, dat};
        rd = '0;
        #13.3;
        for (int i = 39; i >= 0; i--) begin
            drv_val = bits[i];
            #62.5 prog_clock_pin = 1'b1;
            #62.5 prog_clock_pin = 1'b0;
        end
        drv_val = ~drv_val;
        if (cmd == PMT_CMD_PROG_RD || cmd == PMT_CMD_EE_RD) begin
            for (int i = 15; i >= 0; i--) begin
                // pin is retimed on the core clock: sample late in the bit
                #62.5 prog_clock_pin = 1'b1;
                drv_val = ~drv_val;
                #62.4 rd[i] = pin_level;
                #0.1 prog_clock_pin = 1'b0;
            end
        end
        #500;
    endtask : frame
endmodule : pmt_programmer

// ### tb/pmt_table_read_test.sv
// testbench for the table-read and programming block
`timescale 1ns/1ps
module pmt_table_read_test
    import pmt_pkg::*;
;
    logic ref_clk, rst_b, table_rd_req, table_read_alt_op, pc_advance;
    logic [7:0] tbl_ptr_lo, tbl_ptr_hi, operand_addr, dm_addr_q, dm_wdata_q;
    logic [7:0] table_high_latch;
    logic [13:0] pc_q;
    logic [14:0] instr_q;
    logic instr_valid_q, table_busy_q, dm_we_q, core_halt_q, pa0_out, pa0_oe;
    logic pa0_in_q, pa2_in_q, chip_clear_pin_n, prog_data_pin_i, drv_val;
    logic prog_data_pin_o, prog_data_pin_oe, prog_clock_pin;
    int errors, n_checks;

    assign prog_data_pin_i = prog_data_pin_oe ? prog_data_pin_o : drv_val;
    pmt_table_read pmt_table_read_i (.*);
    pmt_programmer pmt_programmer_i (.prog_clock_pin(prog_clock_pin),
        .drv_val(drv_val), .pin_level(prog_data_pin_i));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    task automatic t_prog;
        logic [15:0] rd;
        chip_clear_pin_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        chk(core_halt_q, 1'b1);
        chk({pa0_in_q, pa2_in_q}, 2'b00);
        pmt_programmer_i.frame(PMT_CMD_PROG_WR, 16'h0105, 16'hFABC, rd);
        pmt_programmer_i.frame(PMT_CMD_PROG_WR, 16'h0005, 16'h1234, rd);
        pmt_programmer_i.frame(PMT_CMD_EE_WR, 16'h0012, 16'h005A, rd);
        repeat (2) pmt_programmer_i.frame(PMT_CMD_PROG_RD, 16'h0105, 16'h0, rd);
        chk(rd, 16'h7ABC);
        repeat (2) pmt_programmer_i.frame(PMT_CMD_EE_RD, 16'h0012, 16'h0, rd);
        chk(rd, 16'h005A);
        @(posedge ref_clk);
        chip_clear_pin_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        chk(core_halt_q, 1'b0);
        chk(pc_q, 14'h0000);
    endtask : t_prog

    // request held into the busy cycle, where it must be ignored
    task automatic t_read(input logic alt, input logic [7:0] hi, lo, op,
                          input logic [7:0] exp_lo, exp_hi);
        @(posedge ref_clk);
        table_rd_req <= 1'b1;
        table_read_alt_op <= alt;
        tbl_ptr_hi <= hi;
        tbl_ptr_lo <= lo;
        operand_addr <= op;
        @(posedge ref_clk);
        #1;
        chk(table_busy_q, 1'b1);
        @(posedge ref_clk);
        table_rd_req <= 1'b0;
        #1;
        chk({dm_we_q, instr_valid_q, table_busy_q}, 3'b100);
        chk(dm_addr_q, op);
        chk(dm_wdata_q, exp_lo);
        chk(table_high_latch, exp_hi);
        @(posedge ref_clk);
        #1;
        chk(dm_we_q, 1'b0);
    endtask : t_read

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        {rst_b, table_rd_req, table_read_alt_op, pc_advance} = 4'h0;
        {tbl_ptr_lo, tbl_ptr_hi, operand_addr} = 24'h000000;
        {pa0_out, pa0_oe, chip_clear_pin_n} = 3'b001;
        errors = 0;
        n_checks = 0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(pc_q, 14'h0000);
        chk(core_halt_q, 1'b1);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_prog();
        t_read(1'b1, 8'h01, 8'h05, 8'h21, 8'hBC, 8'h7A);
        t_read(1'b0, 8'h3F, 8'h05, 8'h22, 8'h34, 8'h12);
        report_and_stop();
    end

    initial begin
        #500000;
        errors++;
        report_and_stop();
    end
endmodule : pmt_table_read_test
